//--- verilog/rfc_regs.svh
/*
  timing counts and field codes for the redundancy failover supervisor.
  assumes a 250 MHz clock; included by the design module and the bench.
*/
`ifndef RFC_REGS_SVH
`define RFC_REGS_SVH
`define RFC_CLK_MHZ        250
`define RFC_WDOG_US        1000
`define RFC_WDOG_CYC       (`RFC_WDOG_US * `RFC_CLK_MHZ)
`define RFC_QUERY_US       500
`define RFC_QUERY_CYC      (`RFC_QUERY_US * `RFC_CLK_MHZ)
`define RFC_RETRY_CYC      1024
`define RFC_LOG_DEPTH      64
`define RFC_EV_PRI_FAIL    4'h1
`define RFC_EV_SBY_FAIL    4'h2
`define RFC_EV_LINK_LOST   4'h3
`define RFC_EV_UNMASTERED  4'h4
`define RFC_EV_MASTERED_RX 4'h5
`define RFC_EV_HANDOVER_TX 4'h6
`define RFC_EV_NET_BAD     4'h7
`define RFC_EV_STANDALONE  4'h8
`define RFC_EV_DIAG        4'h9
`endif

//--- verilog/rfc_pkg.sv
/*
  types of the redundancy failover supervisor.
  assumes rfc_regs.svh holds the numeric constants.
*/
package rfc_pkg;
  typedef enum logic [1:0] {RFC_OFFLINE, RFC_STANDBY, RFC_PRIMARY} rfc_role_t;
  typedef enum {RFC_S_IDLE, RFC_S_WDOG, RFC_S_QUERY} rfc_sby_t;
endpackage : rfc_pkg

//--- verilog/rfc_failover.sv
/*
  role supervisor of one unit of a redundant controller pair.
  assumes all inputs come from logic on clk; the peer talks over the
  processor sync link as one-cycle pulses. log memory is assumed to sit on
  a retained supply so its contents outlive a reset.
*/
`timescale 1ns/1ns
`include "rfc_regs.svh"
module rfc_failover
  import rfc_pkg::*;
#(
  parameter int WDOG_CYC  = `RFC_WDOG_CYC,
  parameter int QUERY_CYC = `RFC_QUERY_CYC,
  parameter int RETRY_CYC = `RFC_RETRY_CYC,
  parameter int LOG_DEPTH = `RFC_LOG_DEPTH,
  parameter int LOG_AW    = $clog2(LOG_DEPTH)
)(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              start_primary,
  input  wire logic              start_standby,
  input  wire logic              component_fail,
  input  wire logic              sync_rx_valid,
  input  wire logic              sync_rx_take_control,
  input  wire logic              standby_response_ok,
  input  wire logic              master_task_cycle,
  input  wire logic              net_status_valid,
  input  wire logic              net_status_ok,
  input  wire logic              net_query_reply,
  input  wire logic              net_query_primary_ok,
  input  wire logic              diag_valid,
  input  wire logic [11:0]       diag_code,
  input  wire logic [LOG_AW-1:0] log_rd_addr,
  output logic      [1:0]        role,
  output logic                   drive_outputs,
  output logic                   db_exchange_en,
  output logic                   standalone,
  output logic                   sync_tx_take_control,
  output logic                   net_poll_req,
  output logic                   net_query_req,
  output logic                   link_loss,
  output logic      [15:0]       log_rd_data,
  output logic      [LOG_AW:0]   log_count
);

  // ---------------------------------------------------------------
  // role state
  // ---------------------------------------------------------------
  rfc_role_t         role_reg, role_next;
  rfc_sby_t          sby_reg, sby_next;
  logic [31:0]       wdog_reg, wdog_next;
  logic [31:0]       qry_reg, qry_next;
  logic [31:0]       retry_reg, retry_next;
  logic              alone_reg, alone_next;
  logic              tx_reg, tx_next;
  logic              poll_reg, poll_next;
  logic              qreq_reg, qreq_next;
  logic              loss_reg, loss_next;
  logic              ev_valid;
  logic [3:0]        ev_code;
  logic              drive_reg, drive_next;
  logic              db_reg, db_next;
  logic              stand_reg, stand_next;

  always_comb begin
    role_next  = role_reg;
    sby_next   = sby_reg;
    wdog_next  = wdog_reg;
    qry_next   = qry_reg;
    retry_next = retry_reg;
    alone_next = alone_reg;
    tx_next    = 1'b0;
    poll_next  = 1'b0;
    qreq_next  = 1'b0;
    loss_next  = loss_reg;
    ev_valid   = 1'b0;
    ev_code    = 4'h0;
    case (role_reg)
      RFC_OFFLINE: begin
        sby_next  = RFC_S_IDLE;
        loss_next = 1'b0;
        if (start_primary) begin
          role_next  = RFC_PRIMARY;
          alone_next = 1'b1;
        end else if (start_standby) begin
          role_next = RFC_STANDBY;
          wdog_next = 32'h0;
        end
      end
      RFC_PRIMARY: begin
        // one poll per task cycle, the tick itself is the pacing
        poll_next = master_task_cycle;
        if (standby_response_ok) begin
          alone_next = 1'b0;
        end else if (sync_rx_valid && !standby_response_ok && !alone_reg) begin
          alone_next = 1'b1;
          ev_valid   = 1'b1;
          ev_code    = `RFC_EV_STANDALONE;
        end
        if (component_fail) begin
          // still able to talk: command the handover in the same cycle as going offline
          tx_next   = 1'b1;
          role_next = RFC_OFFLINE;
          ev_valid  = 1'b1;
          ev_code   = `RFC_EV_PRI_FAIL;
        end else if (net_status_valid && !net_status_ok) begin
          tx_next   = 1'b1;
          role_next = RFC_OFFLINE;
          ev_valid  = 1'b1;
          ev_code   = `RFC_EV_NET_BAD;
        end
      end
      RFC_STANDBY: begin
        if (component_fail) begin
          role_next = RFC_OFFLINE;
          ev_valid  = 1'b1;
          ev_code   = `RFC_EV_SBY_FAIL;
        end else if (sync_rx_valid && sync_rx_take_control) begin
          role_next  = RFC_PRIMARY;
          alone_next = 1'b1;
          ev_valid   = 1'b1;
          ev_code    = `RFC_EV_MASTERED_RX;
        end else begin
          case (sby_reg)
            RFC_S_IDLE, RFC_S_WDOG: begin
              if (sync_rx_valid) begin
                wdog_next = 32'h0;
                sby_next  = RFC_S_IDLE;
              end else if (wdog_reg >= 32'(WDOG_CYC - 1)) begin
                // loss only after the whole period; the network module query is raised in the same cycle
                loss_next  = 1'b1;
                qreq_next  = 1'b1;
                qry_next   = 32'h0;
                retry_next = 32'h0;
                sby_next   = RFC_S_QUERY;
                ev_valid   = 1'b1;
                ev_code    = `RFC_EV_LINK_LOST;
              end else begin
                wdog_next = wdog_reg + 32'h1;
                sby_next  = RFC_S_WDOG;
              end
            end
            RFC_S_QUERY: begin
              if (sync_rx_valid) begin
                // primary reappeared; link loss cleared
                loss_next = 1'b0;
                wdog_next = 32'h0;
                sby_next  = RFC_S_IDLE;
              end else if (net_query_reply && net_query_primary_ok) begin
                // primary alive but processor link dead: leave redundancy
                role_next = RFC_OFFLINE;
                ev_valid  = 1'b1;
                ev_code   = `RFC_EV_LINK_LOST;
              end else if (qry_reg >= 32'(QUERY_CYC - 1)) begin
                role_next  = RFC_PRIMARY;
                alone_next = 1'b1;
                loss_next  = 1'b0;
                ev_valid   = 1'b1;
                ev_code    = `RFC_EV_UNMASTERED;
              end else begin
                qry_next = qry_reg + 32'h1;
                if (retry_reg >= 32'(RETRY_CYC - 1)) begin
                  retry_next = 32'h0;
                  qreq_next  = 1'b1;
                end else begin
                  retry_next = retry_reg + 32'h1;
                end
              end
            end
            default: sby_next = RFC_S_IDLE;
          endcase
        end
      end
      default: role_next = RFC_OFFLINE;
    endcase
    // status outputs come from flip-flops, decoded from the next state
    drive_next = (role_next == RFC_PRIMARY);
    db_next    = (role_next != RFC_OFFLINE) && !alone_next;
    stand_next = alone_next && (role_next == RFC_PRIMARY);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      role_reg  <= RFC_OFFLINE;
      sby_reg   <= RFC_S_IDLE;
      wdog_reg  <= 32'h0;
      qry_reg   <= 32'h0;
      retry_reg <= 32'h0;
      alone_reg <= 1'b0;
      tx_reg    <= 1'b0;
      poll_reg  <= 1'b0;
      qreq_reg  <= 1'b0;
      loss_reg  <= 1'b0;
      drive_reg <= 1'b0;
      db_reg    <= 1'b0;
      stand_reg <= 1'b0;
    end else begin
      role_reg  <= role_next;
      sby_reg   <= sby_next;
      wdog_reg  <= wdog_next;
      qry_reg   <= qry_next;
      retry_reg <= retry_next;
      alone_reg <= alone_next;
      tx_reg    <= tx_next;
      poll_reg  <= poll_next;
      qreq_reg  <= qreq_next;
      loss_reg  <= loss_next;
      drive_reg <= drive_next;
      db_reg    <= db_next;
      stand_reg <= stand_next;
    end
  end

  // ---------------------------------------------------------------
  // diagnostic merge
  // ---------------------------------------------------------------
  // a diagnostic that meets a role event waits one slot instead of being
  // lost; only one slot, so a further message inside that burst is dropped
  logic              pend_reg, pend_next;
  logic [11:0]       pend_code_reg, pend_code_next;
  logic              log_we;
  logic [15:0]       log_wdata;

  always_comb begin
    pend_next      = pend_reg;
    pend_code_next = pend_code_reg;
    log_we         = ev_valid;
    log_wdata      = {ev_code, 12'h000};
    if (ev_valid) begin
      if (diag_valid && !pend_reg) begin
        pend_next      = 1'b1;
        pend_code_next = diag_code;
      end
    end else if (pend_reg) begin
      log_we         = 1'b1;
      log_wdata      = {`RFC_EV_DIAG, pend_code_reg};
      pend_next      = diag_valid;
      pend_code_next = diag_code;
    end else if (diag_valid) begin
      log_we    = 1'b1;
      log_wdata = {`RFC_EV_DIAG, diag_code};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pend_reg      <= 1'b0;
      pend_code_reg <= 12'h000;
    end else begin
      pend_reg      <= pend_next;
      pend_code_reg <= pend_code_next;
    end
  end

  // ---------------------------------------------------------------
  // local diagnostic log
  // ---------------------------------------------------------------
  // no reset on the array: contents must survive a unit restart; the
  // log has no path to the sync link so it never reaches the peer
  logic [15:0]       log_mem [LOG_DEPTH];
  logic [LOG_AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [LOG_AW:0]   cnt_reg, cnt_next;
  logic [15:0]       rd_reg, rd_next;

  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    cnt_next    = cnt_reg;
    rd_next     = log_mem[log_rd_addr];
    if (log_we) begin
      wr_ptr_next = wr_ptr_reg + 1'b1;
      if (cnt_reg != (LOG_AW+1)'(LOG_DEPTH)) begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (log_we) begin
      log_mem[wr_ptr_reg] <= log_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      cnt_reg    <= '0;
      rd_reg     <= 16'h0000;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      cnt_reg    <= cnt_next;
      rd_reg     <= rd_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign role                 = role_reg;
  assign drive_outputs        = drive_reg;
  assign db_exchange_en       = db_reg;
  assign standalone           = stand_reg;
  assign sync_tx_take_control = tx_reg;
  assign net_poll_req         = poll_reg;
  assign net_query_req        = qreq_reg;
  assign link_loss            = loss_reg;
  assign log_rd_data          = rd_reg;
  assign log_count            = cnt_reg;

endmodule : rfc_failover

//--- dv/rfc_checker.sv
/*
  port checker of the failover supervisor.
  assumes a bind from the bench; reset is async, active high.
*/
`timescale 1ns/1ns
module rfc_checker #(
  parameter int WDOG_CYC = 20
)(
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       component_fail,
  input wire logic       sync_rx_valid,
  input wire logic       sync_rx_take_control,
  input wire logic       master_task_cycle,
  input wire logic       net_status_valid,
  input wire logic       net_status_ok,
  input wire logic       net_query_reply,
  input wire logic       net_query_primary_ok,
  input wire logic [1:0] role,
  input wire logic       drive_outputs,
  input wire logic       db_exchange_en,
  input wire logic       sync_tx_take_control,
  input wire logic       net_poll_req,
  input wire logic       net_query_req,
  input wire logic       link_loss
);
  // ----------------------------------------
  // silence counter
  // ----------------------------------------
  logic [31:0] sil_reg;
  logic [31:0] sil_next;
  always_comb sil_next = (role == 2'h1 && !sync_rx_valid) ? sil_reg + 32'h1 : 32'h0;
  always_ff @(posedge clk or posedge reset)
    if (reset) sil_reg <= 32'h0;
    else sil_reg <= sil_next;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence handover_s;
    role == 2'h0 && sync_tx_take_control;
  endsequence
  a_pri_fail_handover: assert property (role == 2'h2 && component_fail |=> handover_s)
    else $error("primary fault without handover");
  a_net_bad_handover: assert property (role == 2'h2 && net_status_valid && !net_status_ok |=> handover_s)
    else $error("bad status without handover");
  a_sby_fail_offline: assert property (role == 2'h1 && component_fail && !sync_rx_valid |=> role == 2'h0)
    else $error("failed standby not offline");
  a_take_rx_primary: assert property (role == 2'h1 && sync_rx_valid && sync_rx_take_control && !component_fail
    |=> role == 2'h2)
    else $error("take control ignored");
  a_poll_cause: assert property (net_poll_req |-> $past(master_task_cycle) && $past(role) == 2'h2)
    else $error("poll without task cycle");
  a_poll_follow: assert property (role == 2'h2 && master_task_cycle && !component_fail && !net_status_valid
    |=> net_poll_req)
    else $error("task cycle without poll");
  a_offline_quiet: assert property (role == 2'h0 |-> !drive_outputs && !db_exchange_en)
    else $error("offline unit active");
  a_wdog_full: assert property ($rose(link_loss) |-> sil_reg >= WDOG_CYC)
    else $error("link loss before watchdog");
  a_loss_query: assert property ($rose(link_loss) |-> ##[0:1] net_query_req)
    else $error("no query after link loss");
  a_take_cause: assert property (role == 2'h2 && $past(role) == 2'h1
    |-> $past(link_loss) || ($past(sync_rx_valid) && $past(sync_rx_take_control)))
    else $error("standby promoted without cause");
  a_alive_offline: assert property (role == 2'h1 && link_loss && net_query_reply && net_query_primary_ok
    && !component_fail |=> role == 2'h0)
    else $error("standby kept after link failure");
endmodule : rfc_checker

//--- dv/rfc_peer.sv
/*
  behavioural peer controller on the processor sync link.
  assumes alive and take come from the bench; it updates on the rising edge.
*/
`timescale 1ns/1ns
module rfc_peer (
  input  wire logic clk,
  input  wire logic alive,
  input  wire logic take,
  output logic      sync_rx_valid,
  output logic      sync_rx_take_control,
  output logic      standby_response_ok
);
  logic [2:0] beat_reg;
  logic       tgl_reg;
  initial begin
    beat_reg = 3'h0;
    tgl_reg = 1'b0;
    sync_rx_valid = 1'b0;
    sync_rx_take_control = 1'b0;
    standby_response_ok = 1'b0;
  end
  // qualifier toggles outside messages so a stale level is never trusted
  always @(posedge clk) begin
    beat_reg <= beat_reg + 3'h1;
    tgl_reg <= ~tgl_reg;
    sync_rx_valid <= take || (alive && beat_reg == 3'h0);
    sync_rx_take_control <= take ? 1'b1 : (alive && beat_reg == 3'h0) ? 1'b0 : tgl_reg;
    standby_response_ok <= alive;
  end
endmodule : rfc_peer

//--- dv/rfc_tb.sv
/*
  self-checking bench of the failover supervisor with a peer model.
  assumes short watchdog and query counts given as parameters.
*/
`timescale 1ns/1ns
`include "rfc_regs.svh"
`define CHK(n, e, a) begin \
  compares++; \
  if ((a) !== (e)) begin \
    errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, a); \
  end \
end
module tb;
  import rfc_pkg::*;
  localparam int WD = 20;
  localparam int QRY = 40;
  localparam int RTY = 4;
  logic clk = 1'b0, reset = 1'b1, alive = 1'b0, take = 1'b0;
  logic start_primary, start_standby, component_fail, master_task_cycle, net_status_valid, net_status_ok;
  logic net_query_reply, net_query_primary_ok, diag_valid, sync_rx_valid, sync_rx_take_control;
  logic standby_response_ok, drive_outputs, db_exchange_en, standalone, sync_tx_take_control;
  logic net_poll_req, net_query_req, link_loss;
  logic [11:0] diag_code = 12'h0;
  logic [5:0] log_rd_addr = 6'h0;
  logic [1:0] role;
  logic [15:0] log_rd_data;
  logic [6:0] log_count;
  int errors = 0, compares = 0, n, q;
  always #2 clk = ~clk;
  rfc_failover #(.WDOG_CYC(WD), .QUERY_CYC(QRY), .RETRY_CYC(RTY)) dut (
    .clk(clk), .reset(reset), .start_primary(start_primary), .start_standby(start_standby),
    .component_fail(component_fail), .sync_rx_valid(sync_rx_valid), .sync_rx_take_control(sync_rx_take_control),
    .standby_response_ok(standby_response_ok), .master_task_cycle(master_task_cycle),
    .net_status_valid(net_status_valid), .net_status_ok(net_status_ok), .net_query_reply(net_query_reply),
    .net_query_primary_ok(net_query_primary_ok), .diag_valid(diag_valid), .diag_code(diag_code),
    .log_rd_addr(log_rd_addr), .role(role), .drive_outputs(drive_outputs), .db_exchange_en(db_exchange_en),
    .standalone(standalone), .sync_tx_take_control(sync_tx_take_control), .net_poll_req(net_poll_req),
    .net_query_req(net_query_req), .link_loss(link_loss), .log_rd_data(log_rd_data), .log_count(log_count)
  );
  rfc_peer peer (
    .clk(clk), .alive(alive), .take(take), .sync_rx_valid(sync_rx_valid),
    .sync_rx_take_control(sync_rx_take_control), .standby_response_ok(standby_response_ok)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task cyc(input int k); repeat (k) @(negedge clk); endtask : cyc
  task automatic pulse(ref logic s); s = 1'b1; cyc(1); s = 1'b0; endtask : pulse
  task boot(input logic pri, input logic up);
    {start_primary, start_standby, component_fail, master_task_cycle, net_status_valid} = '0;
    {net_status_ok, net_query_reply, net_query_primary_ok, diag_valid, take} = '0;
    alive = up;
    reset = 1'b1;
    cyc(16);
    reset = 1'b0;
    cyc(1);
    if (pri) pulse(start_primary);
    else pulse(start_standby);
  endtask : boot
  task last_ev(input logic [3:0] ev);
    log_rd_addr = 6'(log_count - 7'h1);
    cyc(2);
    `CHK("event", ev, log_rd_data[15:12])
  endtask : last_ev
  task wait_loss();
    for (n = 0; n < 100 && link_loss !== 1'b1; n++) cyc(1);
  endtask : wait_loss
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_primary();
    boot(1'b1, 1'b0);
    `CHK("standalone", 1'b1, standalone)
    `CHK("db_start", 1'b0, db_exchange_en)
    alive = 1'b1;
    for (n = 0; n < 20 && standalone !== 1'b0; n++) cyc(1);
    `CHK("db_backed", 1'b1, db_exchange_en)
    `CHK("drive", 1'b1, drive_outputs)
    pulse(master_task_cycle);
    `CHK("poll", 1'b1, net_poll_req)
    cyc(1);
    `CHK("poll_once", 1'b0, net_poll_req)
    alive = 1'b0;
    cyc(1);
    pulse(take);
    cyc(1);
    `CHK("alone", 1'b1, standalone)
    `CHK("db_alone", 1'b0, db_exchange_en)
    last_ev(`RFC_EV_STANDALONE);
    component_fail = 1'b1;
    cyc(1);
    `CHK("role", 2'h0, role)
    `CHK("take_tx", 1'b1, sync_tx_take_control)
    `CHK("drive_off", 1'b0, drive_outputs)
    component_fail = 1'b0;
    last_ev(`RFC_EV_PRI_FAIL);
    boot(1'b1, 1'b1);
    pulse(net_status_valid);
    `CHK("role", 2'h0, role)
    `CHK("take_tx", 1'b1, sync_tx_take_control)
    last_ev(`RFC_EV_NET_BAD);
    $display("test primary done");
  endtask : t_primary
  task t_standby();
    boot(1'b0, 1'b1);
    `CHK("role", 2'h1, role)
    component_fail = 1'b1;
    cyc(1);
    `CHK("role", 2'h0, role)
    component_fail = 1'b0;
    last_ev(`RFC_EV_SBY_FAIL);
    boot(1'b0, 1'b1);
    cyc(10);
    pulse(take);
    cyc(1);
    `CHK("role", 2'h2, role)
    last_ev(`RFC_EV_MASTERED_RX);
    $display("test standby done");
  endtask : t_standby
  task t_unmastered();
    boot(1'b0, 1'b1);
    cyc(10);
    // cut the link right on a heartbeat so the silence count starts here
    for (n = 0; n < 10 && sync_rx_valid !== 1'b1; n++) cyc(1);
    alive = 1'b0;
    for (n = 0; n < 100 && link_loss !== 1'b1; n++) begin
      if (sync_rx_valid === 1'b1) n = 0;
      cyc(1);
    end
    `CHK("wdog", 1'b1, n >= WD && n <= WD + 2)
    q = 0;
    for (n = 0; n < 200 && role !== 2'h2; n++) begin
      if (net_query_req === 1'b1) q++;
      cyc(1);
    end
    `CHK("query_time", 1'b1, n >= QRY - 1 && n <= QRY + 2)
    `CHK("retries", 1'b1, q >= QRY / RTY - 1 && q <= QRY / RTY + 1)
    `CHK("role", 2'h2, role)
    last_ev(`RFC_EV_UNMASTERED);
    boot(1'b0, 1'b0);
    wait_loss();
    `CHK("loss", 1'b1, link_loss)
    net_query_primary_ok = 1'b1;
    pulse(net_query_reply);
    `CHK("role", 2'h0, role)
    $display("test unmastered done");
  endtask : t_unmastered
  task t_log();
    boot(1'b0, 1'b1);
    diag_code = 12'h5a3;
    component_fail = 1'b1;
    pulse(diag_valid);
    component_fail = 1'b0;
    cyc(1);
    `CHK("count", 7'h2, log_count)
    log_rd_addr = 6'h1;
    boot(1'b0, 1'b1);
    `CHK("count", 7'h0, log_count)
    cyc(2);
    `CHK("kept", {`RFC_EV_DIAG, 12'h5a3}, log_rd_data)
    $display("test log done");
  endtask : t_log
  task test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  initial begin
    cyc(5000);
    errors++;
    test_done();
  end
  initial begin
    t_primary();
    t_standby();
    t_unmastered();
    t_log();
    test_done();
  end
endmodule : tb
bind rfc_failover rfc_checker #(.WDOG_CYC(WDOG_CYC)) u_chk (
  .clk(clk), .reset(reset), .component_fail(component_fail), .sync_rx_valid(sync_rx_valid),
  .sync_rx_take_control(sync_rx_take_control), .master_task_cycle(master_task_cycle),
  .net_status_valid(net_status_valid), .net_status_ok(net_status_ok), .net_query_reply(net_query_reply),
  .net_query_primary_ok(net_query_primary_ok), .role(role), .drive_outputs(drive_outputs),
  .db_exchange_en(db_exchange_en), .sync_tx_take_control(sync_tx_take_control),
  .net_poll_req(net_poll_req), .net_query_req(net_query_req), .link_loss(link_loss)
);
